//--- hdl/pt_timer.sv
/*
 * Periodic 8-bit timer with pre-divider, period register and post-divider,
 * reached over a classic Wishbone slave.
 * Assumes one 50 MHz clock, synchronous active-high reset, and that the
 * instruction clock is clk_i divided by four, made here as an enable.
 */
`timescale 1ns/1ps

// Function
// - count on instruction clock through pre-divider of one, four or sixteen
// - pre-divider select sits in control bits one to zero
// - select 00 is /1, 01 is /4, 1x is /16
// - count register read/write, cleared to zero by every reset
// - count up from zero; the increment after period match returns to zero
// - period register read/write, reset to FFh
// - matches pass a four-bit post-divider, event every one to sixteen matches
// - post-divider select sits in control bits six to three
// - post select value k divides matches by k plus one
// - divided event sets flag bit one, held until software clears it
// - run bit two of control stops or runs the timer
// - pre- and post-divider counters clear on count write, control write and reset
// - control write leaves the count value untouched
// - undivided period match exported to the serial port
// - count and match exported as the modulation time base
// - control bit seven reads zero and ignores writes
module pt_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire pt_pkg::pt_wb_req_s wb_req_i,
    output pt_pkg::pt_wb_rsp_s wb_rsp_o,
    // time base for serial port and modulation units
    output pt_pkg::pt_tbase_s tbase_o,
    // interrupt
    output logic irq_o
);

    pt_pkg::pt_state_s s_q;
    pt_pkg::pt_state_s s_d;

    localparam int ADDR_HI = pt_pkg::ADDR_W - 1;

    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic wr_count;
    logic wr_control;
    logic wr_period;
    logic wr_flags;
    logic wr_enables;
    logic [3:0] pre_tc;
    logic tick;
    logic inc;
    logic at_period;
    logic post_done;
    logic [7:0] rdat;

    // new request only while no ack is out, giving one idle cycle between
    assign req = wb_req_i.cyc & wb_req_i.stb & ~s_q.rsp.ack;
    assign wr = req & wb_req_i.we & wb_req_i.sel[0];
    assign idx = wb_req_i.adr[ADDR_HI:2];
    assign wdat = wb_req_i.dat[7:0];
    assign wr_count = wr & (idx == pt_pkg::IDX_COUNT);
    assign wr_control = wr & (idx == pt_pkg::IDX_CONTROL);
    assign wr_period = wr & (idx == pt_pkg::IDX_PERIOD);
    assign wr_flags = wr & (idx == pt_pkg::IDX_IRQ_FLAGS);
    assign wr_enables = wr & (idx == pt_pkg::IDX_IRQ_ENABLES);

    // pre-divider decode
    always_comb begin
        unique case (s_q.control[pt_pkg::CTL_PRE_LSB +: 2])
            2'h0: pre_tc = pt_pkg::PRE_TC_1;
            2'h1: pre_tc = pt_pkg::PRE_TC_4;
            default: pre_tc = pt_pkg::PRE_TC_16;
        endcase
    end

    // instruction-clock enable gated by the run bit
    assign tick = s_q.control[pt_pkg::CTL_RUN_BIT] && (s_q.instr_cnt == pt_pkg::INSTR_TC);
    // a write that clears the dividers also drops the carry of that same cycle
    assign inc = tick && (s_q.pre_cnt == pre_tc) && !wr_count && !wr_control;
    assign at_period = (s_q.count == s_q.period);
    assign post_done = (s_q.post_cnt == s_q.control[pt_pkg::CTL_POST_LSB +: 4]);

    always_comb begin
        case (idx)
            pt_pkg::IDX_COUNT: rdat = s_q.count;
            pt_pkg::IDX_CONTROL: rdat = s_q.control;
            pt_pkg::IDX_PERIOD: rdat = s_q.period;
            pt_pkg::IDX_IRQ_FLAGS: rdat = s_q.flags;
            pt_pkg::IDX_IRQ_ENABLES: rdat = s_q.enables;
            default: rdat = 8'h00;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.match = 1'b0;
        s_d.rsp.ack = req;
        s_d.rsp.dat = 32'h0000_0000;
        if (req && !wb_req_i.we) begin
            s_d.rsp.dat = {24'h00_0000, rdat};
        end
        // instruction clock divider is free running
        s_d.instr_cnt = s_q.instr_cnt + 2'h1;
        if (tick) begin
            s_d.pre_cnt = inc ? 4'h0 : s_q.pre_cnt + 4'h1;
        end
        if (inc) begin
            if (at_period) begin
                s_d.count = 8'h00;
                s_d.match = 1'b1;
                s_d.post_cnt = post_done ? 4'h0 : s_q.post_cnt + 4'h1;
            end else begin
                s_d.count = s_q.count + 8'h01;
            end
        end
        // write one to clear; a new event in the same cycle wins
        if (wr_flags) begin
            s_d.flags = s_q.flags & ~wdat;
        end
        if (inc && at_period && post_done) begin
            s_d.flags[pt_pkg::EVT_BIT] = 1'b1;
        end
        if (wr_enables) begin
            s_d.enables = wdat;
        end
        if (wr_period) begin
            s_d.period = wdat;
        end
        if (wr_count) begin
            s_d.count = wdat;
        end
        if (wr_control) begin
            s_d.control = wdat & pt_pkg::CTL_WR_MASK;
        end
        if (wr_count || wr_control) begin
            s_d.pre_cnt = 4'h0;
            s_d.post_cnt = 4'h0;
        end
        s_d.irq = |(s_d.flags & s_d.enables);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.count <= pt_pkg::RST_COUNT;
            s_q.control <= pt_pkg::RST_CONTROL;
            s_q.period <= pt_pkg::RST_PERIOD;
            s_q.flags <= pt_pkg::RST_FLAGS;
            s_q.enables <= pt_pkg::RST_ENABLES;
            s_q.instr_cnt <= 2'h0;
            s_q.pre_cnt <= 4'h0;
            s_q.post_cnt <= 4'h0;
            s_q.match <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.rsp <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_rsp_o = s_q.rsp;
    assign tbase_o = '{count: s_q.count, match: s_q.match};
    assign irq_o = s_q.irq;

    // checks

    AST_CNT_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        (inc && at_period && !wr_count) |=> (s_q.count == 8'h00) && s_q.match)
        else $error("count did not wrap at period");

    AST_CNT_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        (inc && !at_period && !wr_count) |=> (s_q.count == $past(s_q.count) + 8'h01))
        else $error("count did not step by one");

    AST_STOPPED: assert property (@(posedge clk_i) disable iff (rst_i)
        (!s_q.control[2] && !wr_count) |=> (s_q.count == $past(s_q.count)) && !s_q.match)
        else $error("timer moved while stopped");

    AST_CTL_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_control |=> (s_q.count == $past(s_q.count)) && (s_q.pre_cnt == 4'h0))
        else $error("control write disturbed count");

    AST_DIV_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_count |=> (s_q.pre_cnt == 4'h0) && (s_q.post_cnt == 4'h0))
        else $error("dividers not cleared on count write");

    AST_PRE16: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.control[1] && tick && !wr_count && !wr_control)
        |=> (s_q.pre_cnt == $past(s_q.pre_cnt) + 4'h1))
        else $error("divide by sixteen wrong");

    AST_PRE4: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.control[1:0] == 2'h1)
        |-> (s_q.pre_cnt <= 4'h3) && (!inc || (s_q.pre_cnt == 4'h3)))
        else $error("divide by four wrong");

    AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        (inc && at_period && post_done) |=> s_q.flags[1])
        else $error("event flag not set");

    AST_POST1: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.control[6:3] == 4'h0 && inc && at_period) |=> s_q.flags[1])
        else $error("post divide by one missed event");

    AST_BIT7: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_q.control[7])
        else $error("control bit seven set");

    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.irq == |(s_q.flags & s_q.enables))
        else $error("interrupt does not follow flags and enables");

    AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> s_q.rsp.ack ##1 !s_q.rsp.ack)
        else $error("ack not one cycle after request");

    // pre-divider and instruction clock
    AST_TICK_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
        tick
        |=> !tick [*3])
        else $error("instruction ticks closer than four clocks");

    AST_PRE1: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.control[1:0] == 2'h0)
        |-> (s_q.pre_cnt == 4'h0))
        else $error("divide by one pre-divider not idle");

    AST_PRE1_INC: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.control[1:0] == 2'h0 && tick && !wr_count && !wr_control)
        |-> inc)
        else $error("divide by one missed a tick");

    AST_PRE4_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.control[1:0] == 2'h1 && tick && !wr_count && !wr_control)
        |=> (s_q.pre_cnt == (($past(s_q.pre_cnt) == 4'h3) ? 4'h0 : $past(s_q.pre_cnt) + 4'h1)))
        else $error("divide by four stepped wrong");

    AST_PRE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!tick && !wr_count && !wr_control)
        |=> (s_q.pre_cnt == $past(s_q.pre_cnt)))
        else $error("pre-divider moved without a tick");

    // count, match and time base
    AST_CNT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!inc && !wr_count)
        |=> (s_q.count == $past(s_q.count)))
        else $error("count moved without an increment");

    AST_CNT_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_count
        |=> (s_q.count == $past(wdat)))
        else $error("count write lost");

    AST_MATCH_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.match
        |-> (s_q.count == 8'h00))
        else $error("match pulse away from zero count");

    AST_MATCH_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.match
        |=> !s_q.match)
        else $error("match longer than one cycle");

    AST_MATCH_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.match
        |-> $past(inc && at_period))
        else $error("match without a period hit");

    AST_TBASE: assert property (@(posedge clk_i) disable iff (rst_i)
        tbase_o.match
        |-> (tbase_o.count == 8'h00))
        else $error("time base match away from zero");

    // period and control registers
    AST_PER_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_period
        |=> (s_q.period == $past(wdat)))
        else $error("period write lost");

    AST_PER_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_period
        |=> (s_q.period == $past(s_q.period)))
        else $error("period changed without a write");

    AST_CTL_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_control
        |=> (s_q.control == ($past(wdat) & 8'h7F)))
        else $error("control write lost");

    AST_CTL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_control
        |=> (s_q.control == $past(s_q.control)))
        else $error("control changed without a write");

    AST_CTL_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_control
        |=> (s_q.pre_cnt == 4'h0) && (s_q.post_cnt == 4'h0))
        else $error("dividers not cleared on control write");

    // post-divider
    AST_POST_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.post_cnt <= s_q.control[6:3]))
        else $error("post-divider ran past its select");

    AST_POST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!(inc && at_period) && !wr_count && !wr_control)
        |=> (s_q.post_cnt == $past(s_q.post_cnt)))
        else $error("post-divider moved without a match");

    AST_POST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        (inc && at_period && !post_done)
        |=> (s_q.post_cnt == $past(s_q.post_cnt) + 4'h1))
        else $error("post-divider did not step on a match");

    AST_POST16: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.control[6:3] == 4'hF && s_q.post_cnt != 4'hF && !s_q.flags[1])
        |=> !s_q.flags[1])
        else $error("divide by sixteen flagged early");

    // flags, enables and interrupt
    AST_FLAG_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_q.flags[1])
        |-> $past(inc && at_period && post_done))
        else $error("event flag set without a divided match");

    AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.flags[1] && !(wr_flags && wdat[1]))
        |=> s_q.flags[1])
        else $error("event flag dropped without a clear");

    AST_FLAG_W1C: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_flags && wdat[1] && !(inc && at_period && post_done))
        |=> !s_q.flags[1])
        else $error("event flag not cleared by writing one");

    AST_ENA_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_enables
        |=> (s_q.enables == $past(wdat)))
        else $error("enable write lost");

    AST_IRQ_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == (s_q.flags[1] && s_q.enables[1]))
        else $error("interrupt pin does not follow event flag and enable");

    // bus responses
    AST_RD_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_req_i.we && (idx == pt_pkg::IDX_PERIOD))
        |=> (wb_rsp_o.dat == {24'h00_0000, $past(s_q.period)}))
        else $error("period read returned wrong data");

    AST_RSP_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_rsp_o.ack
        |-> (wb_rsp_o.dat == 32'h0000_0000))
        else $error("read data present without ack");

endmodule // pt_timer

//--- hdl/pt_pkg.sv
/*
 * Package for the periodic timer: register offsets, field positions,
 * reset values, divider settings and the carrier structs.
 * Assumes a classic Wishbone slave with 32-bit data, one word a register.
 */
package pt_pkg;

    // register indices; the byte address on the bus is the index times four
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_COUNT = 8'h11;
    localparam logic [7:0] IDX_CONTROL = 8'h12;
    localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PERIOD = 8'h92;
    localparam int ADDR_W = 10;

    // control register fields
    localparam int CTL_PRE_LSB = 0;
    localparam int CTL_RUN_BIT = 2;
    localparam int CTL_POST_LSB = 3;
    localparam logic [7:0] CTL_WR_MASK = 8'h7F;

    // flag / enable bit of the period event
    localparam int EVT_BIT = 1;

    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;

    // pre-divider terminal counts (ratio minus one)
    localparam logic [3:0] PRE_TC_1 = 4'h0;
    localparam logic [3:0] PRE_TC_4 = 4'h3;
    localparam logic [3:0] PRE_TC_16 = 4'hF;
    // instruction clock is the system clock divided by this plus one
    localparam logic [1:0] INSTR_TC = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } pt_wb_req_s;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } pt_wb_rsp_s;

    typedef struct packed {
        logic [7:0] count;
        logic match;
    } pt_tbase_s;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] control;
        logic [7:0] period;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [1:0] instr_cnt;
        logic [3:0] pre_cnt;
        logic [3:0] post_cnt;
        logic match;
        logic irq;
        pt_wb_rsp_s rsp;
    } pt_state_s;

endpackage

//--- testbench/pt_timer_tb_top.sv
/*
 * Self-checking bench for pt_timer: registers, divider ratios, wrap, post-divided
 * flag and interrupt, run control. Assumes 1-cycle Wishbone ack, byte addr = idx*4.
 */
`timescale 1ns/1ps
module pt_timer_tb_top;
    logic clk_i;
    logic rst_i;
    pt_pkg::pt_wb_req_s req;
    pt_pkg::pt_wb_rsp_s rsp;
    pt_pkg::pt_tbase_s tb;
    logic irq;
    int n_fail;
    int total_checks;
    int cyc_n;
    int n;
    int m;
    int t;
    logic [31:0] rd;
    logic [7:0] p;
    logic [3:0] k;
    logic [7:0] idxs [6] = '{8'h0C, 8'h11, 8'h12, 8'h8C, 8'h92, 8'h13};
    logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0};

    pt_timer dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(req),
        .wb_rsp_o(rsp),
        .tbase_o(tb),
        .irq_o(irq)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one classic cycle; request held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int w8;
        @(posedge clk_i);
        req <= '{adr: {idx, 2'b00}, dat: {24'h0, d}, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
        w8 = 0;
        do begin
            @(posedge clk_i);
            w8++;
        end while (rsp.ack !== 1'b1 && w8 < 50);
        rd = rsp.dat;
        req <= '0;
        if (w8 >= 50) n_fail++;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask

    // cycles from the previous sampled match to the next one
    task automatic wait_match();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (tb.match !== 1'b1 && n < 3000);
    endtask

    function automatic int ratio(input logic [1:0] s);
        return s[1] ? 16 : (s[0] ? 4 : 1);
    endfunction

    // hang guard, far above the longest test
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 60000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        rst_i = 1'b1;
        req = '0;
        n_fail = 0;
        total_checks = 0;
        cyc_n = 0;
        void'($urandom(17));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rdc(idxs[i], rstv[i]);
        chk(irq, 1'b0);
        wr(8'h13, 8'hA5);
        rdc(8'h13, 32'h0);
        $display("test reset done");
        wr(pt_pkg::IDX_CONTROL, 8'hFF);
        rdc(pt_pkg::IDX_CONTROL, 32'h7F);
        wr(pt_pkg::IDX_CONTROL, 8'h00);
        p = 8'($urandom_range(254, 1));
        wr(pt_pkg::IDX_COUNT, p);
        wr(pt_pkg::IDX_CONTROL, 8'h10);
        rdc(pt_pkg::IDX_COUNT, {24'h0, p});
        repeat (200) @(posedge clk_i);
        rdc(pt_pkg::IDX_COUNT, {24'h0, p});
        $display("test control done");
        for (int s = 0; s < 4; s++) begin
            p = 8'($urandom_range(7, 1));
            wr(pt_pkg::IDX_CONTROL, 8'h00);
            wr(pt_pkg::IDX_PERIOD, p);
            rdc(pt_pkg::IDX_PERIOD, {24'h0, p});
            wr(pt_pkg::IDX_COUNT, 8'h00);
            wr(pt_pkg::IDX_CONTROL, {5'b00001, s[1:0]});
            wait_match();
            wait_match();
            chk(n, 4 * ratio(s[1:0]) * (p + 1));
            chk(tb.count, 32'h0);
        end
        $display("test ratio done");
        for (int i = 0; i < 5; i++) begin
            k = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom_range(14, 1));
            wr(pt_pkg::IDX_CONTROL, 8'h00);
            wr(pt_pkg::IDX_COUNT, 8'h00);
            wr(pt_pkg::IDX_IRQ_FLAGS, 8'hFF);
            wr(pt_pkg::IDX_IRQ_ENABLES, 8'h02);
            wr(pt_pkg::IDX_PERIOD, 8'h02);
            wr(pt_pkg::IDX_CONTROL, {1'b0, k, 3'b100});
            m = 0;
            t = 0;
            while (irq !== 1'b1 && t < 5000) begin
                @(posedge clk_i);
                t++;
                if (tb.match === 1'b1) m++;
            end
            chk(m, k + 1);
            wr(pt_pkg::IDX_CONTROL, 8'h00);
            rdc(pt_pkg::IDX_IRQ_FLAGS, 32'h2);
            wr(pt_pkg::IDX_IRQ_ENABLES, 8'h00);
            @(posedge clk_i);
            chk(irq, 1'b0);
            wr(pt_pkg::IDX_IRQ_ENABLES, 8'h02);
            wr(pt_pkg::IDX_IRQ_FLAGS, 8'h02);
            rdc(pt_pkg::IDX_IRQ_FLAGS, 32'h0);
            chk(irq, 1'b0);
        end
        $display("test post divider done");
        end_of_test();
    end
endmodule // pt_timer_tb_top
